// ==== acs_cfg.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte addresses on a 32-bit AHB-Lite bus, one byte of data per word
// Notes: definitions only
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

`define ACS_OFF_RES_HI 8'h00
`define ACS_OFF_RES_LO 8'h04
`define ACS_OFF_CTRL0 8'h08
`define ACS_OFF_CTRL1 8'h0C
`define ACS_OFF_CTRL2 8'h10
`define ACS_OFF_CTRL3 8'h14
`define ACS_OFF_CHGRP 8'h18
`define ACS_OFF_ANSEL_LO 8'h1C
`define ACS_OFF_ANSEL_HI 8'h20
`define ACS_OFF_STATUS 8'h24

`define ACS_C0_ON 0
`define ACS_C0_GO 1
`define ACS_C0_MODE_LSB 2
`define ACS_C0_MULTI 4
`define ACS_C2_JUSTIFY 7
`define ACS_C2_ACQ_LSB 3
`define ACS_C2_CLK_LSB 0
`define ACS_ST_DONE 0

`define ACS_CTRL0_WMASK 8'h3D
`define ACS_CTRL1_WMASK 8'hD3
`define ACS_CTRL3_WMASK 8'hDF
`define ACS_ANSEL_HI_WMASK 8'h01
`define ACS_RST_BYTE 8'h00

`define ACS_CONV_TADS 12
`define ACS_POST_TADS 2
`define ACS_SEQ_OVERLAP 12
`define ACS_INSTR_NS 400
`define ACS_HCLK_NS 100
`define ACS_INSTR_CLKS ((`ACS_INSTR_NS + `ACS_HCLK_NS - 1) / `ACS_HCLK_NS)

`endif

// ==== acs_pkg.sv ====
// Purpose: shared types of the conversion sequencer
// Assumes: nothing beyond SystemVerilog packed types
// Notes: constants live in acs_cfg.svh
package acs_pkg;

  typedef enum logic [2:0] {
    ACS_OFF,
    ACS_ACQ,
    ACS_DLY,
    ACS_PACQ,
    ACS_CONV,
    ACS_POST
  } acs_state_t;

  typedef enum logic [1:0] {
    ACS_MODE_SINGLE,
    ACS_MODE_SEQ,
    ACS_MODE_SIMUL,
    ACS_MODE_RSVD
  } acs_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } acs_aphase_t;

  typedef struct packed {
    logic sample_en;
    logic pair_en;
    logic [3:0] channel;
    logic [9:0] dac_code;
  } acs_afe_t;

endpackage : acs_pkg

// ==== acs_tad_gen.sv ====
// Purpose: bit period tick from the oscillator divider or the RC source
// Assumes: rc_tick is a one-cycle pulse synchronous to hclk
// Notes: divider restarts whenever run is low
`timescale 1ns/1ns
module acs_tad_gen #(
  parameter int DIV_W = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  input wire logic rc_tick,
  output logic tad_tick
);

  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] div_last;
  logic [2:0] idx;
  logic use_rc;
  logic step;
  logic wrap;

  initial begin
    if (DIV_W < 7) $error("acs_tad_gen: DIV_W must be at least 7");
  end

  // RULE_18 clock code decode
  assign idx = {clk_sel[1:0], clk_sel[2]};
  assign use_rc = (idx == 3'd6) || (idx == 3'd7);
  assign div_last = (idx == 3'd6) ? DIV_W'(3) :
                    (idx == 3'd7) ? DIV_W'(0) : DIV_W'((2 << idx) - 1);
  assign step = use_rc ? rc_tick : 1'b1;
  assign wrap = step && (cnt_ff >= div_last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
    end else if (!run || wrap) begin
      cnt_ff <= '0;
    end else if (step) begin
      cnt_ff <= cnt_ff + DIV_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tad_tick <= 1'b0;
    end else begin
      tad_tick <= run && wrap;
    end
  end

endmodule : acs_tad_gen

// ==== acs_top.sv ====
// Purpose: 10-bit successive-approximation converter sequencer behind AHB-Lite
// Assumes: single word transfers, cmp_hi valid at each bit period tick
// Notes: writes take no wait state, reads take one
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "acs_cfg.svh"
// Behaviour
// RULE_01: Zero acquisition select delays conversion start by one instruction time; the code delays it in single-shot mode only.
// RULE_02: Software selects the RC clock for conversions in Sleep.
// RULE_03: Acquisition select 0010 samples four bit periods then converts.
// RULE_04: Clearing go during a conversion aborts it at once.
// RULE_05: Abort leaves the partial sample in the result pair.
// RULE_06: Abort raises no completion flag; software reads partial result promptly.
// RULE_07: Two bit periods of wait follow every finished or aborted conversion; the code skips it between the two conversions of a simultaneous pair.
// RULE_08: After that wait acquisition of the selected channel restarts automatically.
// RULE_09: Software turns the converter on before setting go.
// RULE_10: Conversion end loads the 10-bit result into the byte pair.
// RULE_11: Justify select places the result left or right.
// RULE_12: The six unused result bits load as zero.
// RULE_13: Result bytes are plain read-write storage while disabled.
// RULE_14: Sequential mode shortens later acquisitions by twelve bit periods.
// RULE_15: Simultaneous mode samples a pair, converts both, then the next pair.
// RULE_16: Each conversion takes exactly twelve bit periods.
// RULE_17: Zero acquisition select starts conversion without acquisition delay.
// RULE_18: Clock select codes pick 2..64 oscillator periods, RC or RC/4.
// RULE_19: Conversions in Sleep are allowed only in single-shot mode.
// RULE_20: Normal completion clears go and sets the completion flag.
// RULE_21: Programmed acquisition is counted in bit periods.
module acs_top import acs_pkg::*; #(
  parameter int INSTR_CLKS = `ACS_INSTR_CLKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rc_tick,
  input wire logic sleep_mode,
  input wire logic cmp_hi,
  output acs_afe_t afe,
  output logic busy
);

  initial begin
    if (INSTR_CLKS < 1 || INSTR_CLKS > 255) $error("acs_top: INSTR_CLKS out of range");
  end

  acs_state_t state_ff;
  acs_aphase_t aph_ff;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] res_hi_ff, res_lo_ff, ctrl0_ff, ctrl1_ff, ctrl2_ff, ctrl3_ff;
  logic [7:0] chgrp_ff, ansel_lo_ff, ansel_hi_ff;
  logic go_ff;
  logic done_ff;
  logic [4:0] tcnt_ff;
  logic [7:0] dly_ff;
  logic [1:0] chan_ff;
  logic [9:0] sar_ff, trial_ff, mask_ff;
  logic tad_tick;
  logic [7:0] wbyte;
  logic wr_c0, go_set, go_clr, start, abort, conv_end, last_conv, pair_next;
  logic [4:0] acq_tads, acq_next, acq_len;
  logic [9:0] sar_next, result;
  acs_mode_t mode;
  logic [7:0] rd_mux;

  assign wbyte = hwdata[7:0];
  assign mode = ctrl0_ff[`ACS_C0_MULTI] ? acs_mode_t'(ctrl0_ff[`ACS_C0_MODE_LSB +: 2]) : ACS_MODE_SINGLE;
  assign wr_c0 = wr_pend_ff && (aph_ff.addr == `ACS_OFF_CTRL0);
  // RULE_19 sleep single only
  assign go_set = wr_c0 && wbyte[`ACS_C0_GO] && !go_ff && ctrl0_ff[`ACS_C0_ON]
                  && !(sleep_mode && mode != ACS_MODE_SINGLE);
  assign go_clr = wr_c0 && !wbyte[`ACS_C0_GO] && go_ff;
  assign start = go_set && (state_ff == ACS_ACQ);
  // RULE_04 abort on go clear
  assign abort = go_clr && (state_ff == ACS_DLY || state_ff == ACS_PACQ || state_ff == ACS_CONV);
  assign conv_end = (state_ff == ACS_CONV) && tad_tick && (tcnt_ff == 5'(`ACS_CONV_TADS - 1)) && !abort;
  assign last_conv = (mode == ACS_MODE_SINGLE) || (mode == ACS_MODE_RSVD) || (chan_ff == 2'd3);
  assign pair_next = (mode == ACS_MODE_SIMUL) && !chan_ff[0];
  // RULE_21 acquisition in bit periods
  assign acq_tads = {ctrl2_ff[`ACS_C2_ACQ_LSB +: 4], 1'b0};
  // RULE_14 overlap shortens acquisition
  assign acq_next = (mode == ACS_MODE_SEQ) ?
                    ((acq_tads > 5'(`ACS_SEQ_OVERLAP)) ? acq_tads - 5'(`ACS_SEQ_OVERLAP) : 5'd0) : acq_tads;
  // First acquisition of a sequence is never shortened
  assign acq_len = (chan_ff == 2'd0) ? acq_tads : acq_next;
  assign sar_next = cmp_hi ? trial_ff : sar_ff;
  assign result = sar_ff;

  acs_tad_gen #(
    .DIV_W(7)
  ) u_tad (
    .hclk(hclk),
    .hresetn(hresetn),
    // Abort restarts the divider so the wait gets two whole periods
    .run((state_ff == ACS_PACQ || state_ff == ACS_CONV || state_ff == ACS_POST) && !abort),
    .clk_sel(ctrl2_ff[`ACS_C2_CLK_LSB +: 3]),
    .rc_tick(rc_tick),
    .tad_tick(tad_tick)
  );

  // Bus address phase; reads get one wait state so data comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff <= '0;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        aph_ff <= '{addr: haddr[7:0], write: hwrite};
        wr_pend_ff <= hwrite;
        rd_pend_ff <= !hwrite;
      end
    end
  end

  always_comb begin
    case (aph_ff.addr)
      `ACS_OFF_RES_HI: rd_mux = res_hi_ff;
      `ACS_OFF_RES_LO: rd_mux = res_lo_ff;
      `ACS_OFF_CTRL0: rd_mux = {ctrl0_ff[7:2], go_ff, ctrl0_ff[0]};
      `ACS_OFF_CTRL1: rd_mux = ctrl1_ff;
      `ACS_OFF_CTRL2: rd_mux = ctrl2_ff;
      `ACS_OFF_CTRL3: rd_mux = ctrl3_ff;
      `ACS_OFF_CHGRP: rd_mux = chgrp_ff;
      `ACS_OFF_ANSEL_LO: rd_mux = ansel_lo_ff;
      `ACS_OFF_ANSEL_HI: rd_mux = ansel_hi_ff;
      `ACS_OFF_STATUS: rd_mux = {7'h00, done_ff};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      hreadyout <= !(hsel && hready && htrans[1] && !hwrite);
      if (rd_pend_ff) begin
        hrdata <= {24'h000000, rd_mux};
      end
    end
  end

  // Plain configuration storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_ff <= `ACS_RST_BYTE;
      ctrl1_ff <= `ACS_RST_BYTE;
      ctrl2_ff <= `ACS_RST_BYTE;
      ctrl3_ff <= `ACS_RST_BYTE;
      chgrp_ff <= `ACS_RST_BYTE;
      ansel_lo_ff <= `ACS_RST_BYTE;
      ansel_hi_ff <= `ACS_RST_BYTE;
    end else if (wr_pend_ff) begin
      case (aph_ff.addr)
        `ACS_OFF_CTRL0: ctrl0_ff <= wbyte & `ACS_CTRL0_WMASK;
        `ACS_OFF_CTRL1: ctrl1_ff <= wbyte & `ACS_CTRL1_WMASK;
        `ACS_OFF_CTRL2: ctrl2_ff <= wbyte;
        `ACS_OFF_CTRL3: ctrl3_ff <= wbyte & `ACS_CTRL3_WMASK;
        `ACS_OFF_CHGRP: chgrp_ff <= wbyte;
        `ACS_OFF_ANSEL_LO: ansel_lo_ff <= wbyte;
        `ACS_OFF_ANSEL_HI: ansel_hi_ff <= wbyte & `ACS_ANSEL_HI_WMASK;
        default: ;
      endcase
    end
  end

  // Go flag: software write wins only when it clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_ff <= 1'b0;
    end else if (go_clr || (wr_c0 && !wbyte[`ACS_C0_ON])) begin
      go_ff <= 1'b0;
    end else if (start) begin
      go_ff <= 1'b1;
    // RULE_20 done clears go
    end else if (conv_end && last_conv) begin
      go_ff <= 1'b0;
    end
  end

  // RULE_06 flag only on completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_ff <= 1'b0;
    end else if (conv_end && last_conv) begin
      done_ff <= 1'b1;
    end else if (wr_pend_ff && aph_ff.addr == `ACS_OFF_STATUS && wbyte[`ACS_ST_DONE]) begin
      done_ff <= 1'b0;
    end
  end

  // Result pair: hardware load beats a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_hi_ff <= `ACS_RST_BYTE;
      res_lo_ff <= `ACS_RST_BYTE;
    // RULE_10 load result pair
    // RULE_05 partial kept on abort
    end else if (conv_end || (abort && state_ff == ACS_CONV)) begin
      // RULE_11 justify select
      // RULE_12 unused bits zero
      if (ctrl2_ff[`ACS_C2_JUSTIFY]) begin
        {res_hi_ff, res_lo_ff} <= {6'h00, result};
      end else begin
        {res_hi_ff, res_lo_ff} <= {result, 6'h00};
      end
    // RULE_13 plain storage
    end else if (wr_pend_ff && aph_ff.addr == `ACS_OFF_RES_HI) begin
      res_hi_ff <= wbyte;
    end else if (wr_pend_ff && aph_ff.addr == `ACS_OFF_RES_LO) begin
      res_lo_ff <= wbyte;
    end
  end

  // Sequencer state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ACS_OFF;
    end else if (!ctrl0_ff[`ACS_C0_ON]) begin
      state_ff <= ACS_OFF;
    end else begin
      case (state_ff)
        ACS_OFF: state_ff <= ACS_ACQ;
        ACS_ACQ: begin
          if (start) begin
            // RULE_01 delayed start
            // RULE_17 no acquisition delay
            if (acq_tads == 5'd0) begin
              state_ff <= (mode == ACS_MODE_SINGLE) ? ACS_DLY : ACS_CONV;
            // RULE_03 programmed acquisition
            end else begin
              state_ff <= ACS_PACQ;
            end
          end
        end
        ACS_DLY: begin
          if (abort) begin
            state_ff <= ACS_POST;
          end else if (dly_ff == 8'(INSTR_CLKS - 1)) begin
            state_ff <= ACS_CONV;
          end
        end
        ACS_PACQ: begin
          if (abort) begin
            state_ff <= ACS_POST;
          end else if (tad_tick && tcnt_ff == acq_len - 5'd1) begin
            state_ff <= ACS_CONV;
          end
        end
        ACS_CONV: begin
          // RULE_07 wait after conversion
          if (abort || (conv_end && last_conv)) begin
            state_ff <= ACS_POST;
          // RULE_15 pair back to back
          end else if (conv_end && pair_next) begin
            state_ff <= ACS_CONV;
          end else if (conv_end) begin
            state_ff <= ACS_POST;
          end
        end
        ACS_POST: begin
          if (tad_tick && tcnt_ff == 5'(`ACS_POST_TADS - 1)) begin
            // RULE_08 auto reacquire
            if (!go_ff) begin
              state_ff <= ACS_ACQ;
            end else if (acq_next == 5'd0) begin
              state_ff <= ACS_CONV;
            end else begin
              state_ff <= ACS_PACQ;
            end
          end
        end
        default: state_ff <= ACS_OFF;
      endcase
    end
  end

  // Bit period and instruction counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcnt_ff <= 5'd0;
      dly_ff <= 8'h00;
    end else begin
      dly_ff <= (state_ff == ACS_DLY) ? dly_ff + 8'h01 : 8'h00;
      if (state_ff == ACS_ACQ || state_ff == ACS_DLY || state_ff == ACS_OFF || abort || conv_end) begin
        tcnt_ff <= 5'd0;
      end else if (tad_tick) begin
        // RULE_16 twelve bit periods
        if ((state_ff == ACS_PACQ && tcnt_ff == acq_len - 5'd1) ||
            (state_ff == ACS_POST && tcnt_ff == 5'(`ACS_POST_TADS - 1))) begin
          tcnt_ff <= 5'd0;
        end else begin
          tcnt_ff <= tcnt_ff + 5'd1;
        end
      end
    end
  end

  // Channel index steps after each conversion of a sequence except the last
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_ff <= 2'd0;
    end else if (start || state_ff == ACS_ACQ) begin
      chan_ff <= 2'd0;
    end else if (conv_end && !last_conv) begin
      chan_ff <= chan_ff + 2'd1;
    end
  end

  // Successive approximation: bit 9 tried at count 1, bit 0 judged at count 10
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sar_ff <= 10'h000;
      trial_ff <= 10'h000;
      mask_ff <= 10'h000;
    end else if (state_ff != ACS_CONV || conv_end) begin
      sar_ff <= 10'h000;
      trial_ff <= 10'h200;
      mask_ff <= 10'h200;
    end else if (tad_tick && tcnt_ff >= 5'd1 && tcnt_ff <= 5'd10) begin
      sar_ff <= sar_next;
      mask_ff <= mask_ff >> 1;
      trial_ff <= sar_next | (mask_ff >> 1);
    end
  end

  // Front end drive; sampling held open only in the ACQ and PACQ states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      afe <= '0;
      busy <= 1'b0;
    end else begin
      afe.sample_en <= (state_ff == ACS_ACQ || state_ff == ACS_PACQ);
      afe.pair_en <= (mode == ACS_MODE_SIMUL);
      afe.channel <= (mode == ACS_MODE_SINGLE || mode == ACS_MODE_RSVD) ?
                     {2'd0, chgrp_ff[1:0]} : {chan_ff, chgrp_ff[2*chan_ff +: 2]};
      afe.dac_code <= trial_ff;
      busy <= go_ff;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_conv_done; conv_end && last_conv |=> done_ff && !go_ff; endproperty
  a_conv_done: assert property (p_conv_done) else $error("completion flag or go wrong"); // RULE_20
  property p_abort_noflag; abort && !done_ff |=> !done_ff && state_ff == ACS_POST; endproperty
  a_abort_noflag: assert property (p_abort_noflag) else $error("abort raised flag"); // RULE_06
  property p_post_after; state_ff == ACS_CONV && (abort || (conv_end && last_conv)) |=> state_ff == ACS_POST;
  endproperty
  a_post_after: assert property (p_post_after) else $error("no wait after conversion"); // RULE_07
  property p_reacq; state_ff == ACS_POST && tad_tick && tcnt_ff == 5'd1 && !go_ff && ctrl0_ff[0]
    |=> state_ff == ACS_ACQ ##1 afe.sample_en; endproperty
  a_reacq: assert property (p_reacq) else $error("no reacquisition"); // RULE_08
  property p_conv_len; $rose(state_ff == ACS_CONV) |-> tcnt_ff == 5'd0; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion count overrun"); // RULE_16
  property p_right; conv_end && ctrl2_ff[7] |=> res_hi_ff[7:2] == 6'h00; endproperty
  a_right: assert property (p_right) else $error("right justify bits not zero"); // RULE_12
  property p_left; conv_end && !ctrl2_ff[7] |=> res_lo_ff[5:0] == 6'h00 && res_hi_ff == $past(sar_ff[9:2]);
  endproperty
  a_left: assert property (p_left) else $error("left justify wrong"); // RULE_11
  property p_delay; start && acq_tads == 5'd0 && mode == ACS_MODE_SINGLE |=> state_ff == ACS_DLY;
  endproperty
  a_delay: assert property (p_delay) else $error("zero acquisition start not delayed"); // RULE_01
  property p_acq4; start && ctrl2_ff[6:3] == 4'h2 |=> state_ff == ACS_PACQ; endproperty
  a_acq4: assert property (p_acq4) else $error("programmed acquisition skipped"); // RULE_03
  property p_sleep; sleep_mode && mode != ACS_MODE_SINGLE && !go_ff |=> !go_ff; endproperty
  a_sleep: assert property (p_sleep) else $error("multi-channel start in sleep"); // RULE_19

  c_done: cover property (conv_end && last_conv);
  c_abort: cover property (abort && state_ff == ACS_CONV);
  c_pair: cover property (conv_end && pair_next);
  c_seq: cover property (conv_end && mode == ACS_MODE_SEQ && chan_ff == 2'd3);

endmodule : acs_top

// ==== acs_analog_model.sv ====
// Purpose: analog channel model behind the sample-and-hold front end
// Assumes: comparator judged against afe.dac_code
// Notes: held level follows the input only while the switch is closed
`timescale 1ns/1ns
module acs_analog_model import acs_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire acs_afe_t afe,
  input wire logic [9:0] level,
  output logic cmp_hi
);
  logic [9:0] held_ff;

  // Hold capacitor, frozen once sampling stops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_ff <= 10'h000;
    end else if (afe.sample_en) begin
      held_ff <= level;
    end
  end

  assign cmp_hi = (held_ff >= afe.dac_code);
endmodule : acs_analog_model

// ==== adc_conversion_sequencer_bench.sv ====
// Purpose: self-checking bench of the conversion sequencer
// Assumes: hready tied to hreadyout, one bus master
// Notes: reads queue their expectation, a monitor compares
`timescale 1ns/1ns
`include "acs_cfg.svh"
module adc_conversion_sequencer_bench import acs_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, rc_tick, sleep_mode, cmp_hi, hreadyout, hresp, busy, rd_pend;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] level;
  logic [7:0] hold;
  logic [15:0] mon_e;
  acs_afe_t afe;
  logic [15:0] exp_q[$];
  int failures, check_count, cyc, rc_cnt;
  // Clocks per bit period, indexed by clock select code
  int tads[8] = '{2, 8, 32, 20, 4, 16, 64, 5};

  acs_top #(.INSTR_CLKS(4)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rc_tick(rc_tick),
    .sleep_mode(sleep_mode), .cmp_hi(cmp_hi), .afe(afe), .busy(busy));
  acs_analog_model model_u (.hclk(hclk), .hresetn(hresetn), .afe(afe), .level(level), .cmp_hi(cmp_hi));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // RC source every five clocks, and the hang limit
  always @(posedge hclk) begin
    rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
    rc_tick <= (rc_cnt == 4);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // Read data taken at the edge that ends the data phase, one edge after the wait state ends
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      mon_e = exp_q.pop_front();
      check(hrdata & {24'hFFFFFF, mon_e[15:8]}, {24'h0, mon_e[7:0]});
      rd_pend <= 1'b0;
    end
    if (hsel && htrans[1] && hreadyout && !hwrite) begin
      rd_pend <= 1'b1;
    end
  end

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    exp_q.push_back({m, e & m});
    bus(a, 1'b0, 8'h00);
  endtask : rd

  // Sampling must resume after the two-period wait
  task automatic wait_idle(input int d);
    int n;
    n = 0;
    while (afe.sample_en !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    check(32'(n >= d && n <= 2 * d + 3), 32'h1);
  endtask : wait_idle

  task automatic convert(input logic [2:0] cs, input logic [3:0] acq, input logic [7:0] c0 = 8'h01);
    logic rj;
    logic [9:0] v;
    int n, d, lo, a;
    rj = 1'($urandom);
    v = 10'($urandom);
    d = tads[cs];
    a = 2 * acq;
    // Bit periods per sequence: sequential overlaps, simultaneous pairs
    lo = (c0 == 8'h15) ? a + 48 + 3 * (2 + (a > 12 ? a - 12 : 0)) : (c0 == 8'h19) ? 2 * a + 50 : 12 + a;
    level <= v;
    // sleep only on the RC clock
    sleep_mode <= (cs == 3'h7);
    wr(`ACS_OFF_CTRL2, {rj, acq, cs});
    wr(`ACS_OFF_CTRL0, c0);
    wr(`ACS_OFF_CTRL0, c0 | 8'h02);
    n = 0;
    // Busy rises at the first edge after the go write
    do begin
      @(posedge hclk);
      n++;
    end while ((busy === 1'b1 || n < 2) && n < 3000);
    check(32'(n >= lo * d && n <= lo * d + 2 * d + 8), 32'h1);
    check(32'(afe.pair_en), 32'(c0 == 8'h19));
    wait_idle(d);
    sleep_mode <= 1'b0;
    rd(`ACS_OFF_RES_HI, rj ? {6'h0, v[9:8]} : v[9:2]);
    rd(`ACS_OFF_RES_LO, rj ? v[7:0] : {v[1:0], 6'h0});
    rd(`ACS_OFF_STATUS, 8'h01);
    rd(`ACS_OFF_CTRL0, c0);
    wr(`ACS_OFF_STATUS, 8'h01);
    rd(`ACS_OFF_STATUS, 8'h00);
  endtask : convert

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rc_tick = 1'b0;
    sleep_mode = 1'b0;
    level = 10'h000;
    rd_pend = 1'b0;
    failures = 0;
    check_count = 0;
    cyc = 0;
    rc_cnt = 0;
    void'($urandom(16789));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, one unmapped word included
    for (int i = 0; i < 11; i++) begin
      rd(8'(4 * i), `ACS_RST_BYTE);
    end
    for (int i = 0; i < 2; i++) begin
      hold = 8'($urandom);
      wr(8'(4 * i), hold);
      rd(8'(4 * i), hold);
    end
    wr(`ACS_OFF_CTRL1, 8'hFF);
    rd(`ACS_OFF_CTRL1, `ACS_CTRL1_WMASK);
    wr(`ACS_OFF_CTRL3, 8'hFF);
    rd(`ACS_OFF_CTRL3, `ACS_CTRL3_WMASK);
    wr(`ACS_OFF_ANSEL_HI, 8'hFF);
    rd(`ACS_OFF_ANSEL_HI, `ACS_ANSEL_HI_WMASK);
    wr(8'h28, 8'hFF);
    rd(8'h28, 8'h00);
    // Go in the enabling write is dropped
    wr(`ACS_OFF_CTRL0, 8'h03);
    rd(`ACS_OFF_CTRL0, 8'h01);
    // Multi-channel start refused in sleep
    sleep_mode <= 1'b1;
    wr(`ACS_OFF_CTRL0, 8'h15);
    wr(`ACS_OFF_CTRL0, 8'h17);
    rd(`ACS_OFF_CTRL0, 8'h15);
    sleep_mode <= 1'b0;
    wr(`ACS_OFF_CTRL0, 8'h01);
    for (int k = 0; k < 16; k++) begin
      convert(3'(k), k < 8 ? 4'h0 : (k == 15 ? 4'h5 : 4'h2));
    end
    convert(3'h0, 4'hA, 8'h15);
    convert(3'h0, 4'hA, 8'h19);
    // Abort a slow conversion a few bit periods in
    wr(`ACS_OFF_CTRL0, 8'h00);
    wr(`ACS_OFF_RES_HI, 8'h00);
    wr(`ACS_OFF_CTRL0, 8'h01);
    level <= {1'b1, 9'($urandom)};
    wr(`ACS_OFF_CTRL2, 8'h06);
    wr(`ACS_OFF_CTRL0, 8'h03);
    repeat (300) @(posedge hclk);
    wr(`ACS_OFF_CTRL0, 8'h01);
    repeat (2) @(posedge hclk);
    check(32'(busy), 32'h0);
    wait_idle(64);
    rd(`ACS_OFF_STATUS, 8'h00);
    rd(`ACS_OFF_RES_HI, 8'h80, 8'h80);
    print_verdict();
  end
endmodule : adc_conversion_sequencer_bench
